// ### usart_buf_defines.svh
// Register offsets, field positions, reset values and encodings for the data buffer block
`ifndef USART_BUF_DEFINES_SVH
`define USART_BUF_DEFINES_SVH
// Register indices (byte address is four times the index)
`define IDX_RX_LOW 4'h0
`define IDX_RX_HIGH 4'h1
`define IDX_TX_LOW 4'h2
`define IDX_TX_HIGH 4'h3
`define IDX_STATUS 4'h4
`define IDX_IRQ_EN 4'h5
`define IDX_RXTX_EN 4'h6
`define IDX_FRAME 4'h7
`define IDX_BAUD_LO 4'h8
`define IDX_BAUD_HI 4'h9
`define IDX_RSVD 4'hA
`define IDX_DBG 4'hB
`define IDX_EVT 4'hC
`define IDX_TXPL 4'hD
`define IDX_RXPL 4'hE
// Receive high byte fields
`define RXH_COMPLETE 7
`define RXH_OVERRUN 6
`define RXH_STOP_ERR 2
`define RXH_PAR_ERR 1
`define RXH_BIT8 0
// Status fields
`define ST_RXC 7
`define ST_TXC 6
`define ST_DRE 5
`define ST_RXS 4
// Receiver/transmitter enable register fields
`define EN_RX 7
`define EN_TX 6
`define EN_SFD 4
`define EN_RXMODE_HI 2
`define EN_RXMODE_LO 1
// Frame format fields
`define FR_CMODE_HI 7
`define FR_CMODE_LO 6
`define FR_PMODE_HI 5
`define FR_PMODE_LO 4
`define FR_SIZE_HI 2
`define FR_SIZE_LO 0
// Encodings
`define CMODE_SPI_MASTER 2'h3
`define RXMODE_BUS_AUTO 2'h3
`define PMODE_OFF 2'h0
`define SIZE_5 3'h0
`define SIZE_6 3'h1
`define SIZE_7 3'h2
`define SIZE_9_LOW_FIRST 3'h6
`define SIZE_9_HIGH_FIRST 3'h7
// Reset values
`define RST_BYTE 8'h00
`endif

// ### usart_buf_pkg.sv
// Types shared by the data buffer block and its neighbours
package usart_buf_pkg;
  // One character delivered by the receive shift logic
  typedef struct packed {
    logic [8:0] data;
    logic stop_err;
    logic par_err;
    logic in_response;
  } rx_char_t;
  // One receive buffer entry
  typedef struct packed {
    logic [8:0] data;
    logic stop_err;
    logic par_err;
    logic overrun;
  } rx_entry_t;
  // Settings handed to the shift logic
  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic [2:0] char_size;
    logic [1:0] rx_mode;
    logic [1:0] cmode;
    logic [1:0] pmode;
    logic [15:0] baud;
  } line_cfg_t;
endpackage

// ### usart_data_buffer_regs.sv
// Receive FIFO, transmit holding buffer and APB register bank of the serial transceiver
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "usart_buf_defines.svh"
module usart_data_buffer_regs
  import usart_buf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive shift logic
  input wire logic rx_push,
  input wire rx_char_t rx_char,
  input wire logic rx_shift_full,
  input wire logic rx_start_det,
  output logic rx_fifo_full,
  // Transmit shift logic
  input wire logic tx_shift_empty,
  input wire logic tx_done,
  output logic tx_load,
  output logic [8:0] tx_load_data,
  // Settings and interrupt
  output line_cfg_t line_cfg,
  output logic irq
);

  // Keep only the bits a character of the given size uses
  function automatic logic [8:0] mask_char(input logic [8:0] d, input logic [2:0] size);
    logic [8:0] m;
    m = 9'h0FF;
    case (size)
      `SIZE_5: m = 9'h01F;
      `SIZE_6: m = 9'h03F;
      `SIZE_7: m = 9'h07F;
      `SIZE_9_LOW_FIRST, `SIZE_9_HIGH_FIRST: m = 9'h1FF;
      default: m = 9'h0FF;
    endcase
    return d & m;
  endfunction

  // Nine-bit size with the low byte handled first
  function automatic logic low_first(input logic [2:0] size);
    return size == `SIZE_9_LOW_FIRST;
  endfunction

  // Register state
  logic [7:0] irq_en_q;
  logic [7:0] rxtx_en_q;
  logic [7:0] frame_q;
  logic [7:0] baud_lo_q;
  logic [7:0] baud_hi_q;
  logic [7:0] dbg_q;
  logic [7:0] evt_q;
  logic [7:0] txpl_q;
  logic [7:0] rxpl_q;
  logic txc_q;
  logic rxs_q;
  rx_entry_t fifo_q [0:1];
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic ovf_pend_q;
  logic [7:0] tx_low_q;
  logic tx_bit8_q;
  logic dre_q;
  logic tx_wait_high_q;
  logic rd_had_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic tx_load_q;
  logic [8:0] tx_load_data_q;
  logic irq_q;
  logic full_q;

  // Decoded settings
  logic [3:0] idx;
  logic addr_ok;
  logic xfer;
  logic wr;
  logic rd;
  logic rx_enable;
  logic spi_master;
  logic bus_auto;
  logic parity_on;
  logic [2:0] size;
  logic pop;
  logic push;
  logic load;
  rx_entry_t head;
  rx_entry_t new_entry;
  logic [7:0] rx_high;
  logic [7:0] status;

  assign idx = paddr[5:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (idx <= `IDX_RXPL);
  assign xfer = psel && penable && pready_q;
  assign wr = xfer && pwrite && addr_ok;
  assign rd = xfer && !pwrite && addr_ok;
  assign rx_enable = rxtx_en_q[`EN_RX];
  assign spi_master = frame_q[`FR_CMODE_HI:`FR_CMODE_LO] == `CMODE_SPI_MASTER;
  assign bus_auto = rxtx_en_q[`EN_RXMODE_HI:`EN_RXMODE_LO] == `RXMODE_BUS_AUTO;
  assign parity_on = frame_q[`FR_PMODE_HI:`FR_PMODE_LO] != `PMODE_OFF;
  assign size = frame_q[`FR_SIZE_HI:`FR_SIZE_LO];
  assign head = fifo_q[rd_ptr_q];

  assign pop = rd && rd_had_q && (count_q != 2'h0) &&
               (low_first(size) ? (idx == `IDX_RX_HIGH) : (idx == `IDX_RX_LOW));
  // Shifter may only push into free room
  assign push = rx_push && rx_enable && (count_q != 2'h2 || pop);

  // Entry built from the shifter's character
  always_comb begin
    new_entry = '0;
    new_entry.data = mask_char(rx_char.data, size);
    if (bus_auto) begin
      new_entry.data[8] = rx_char.in_response;
    end
    new_entry.stop_err = rx_char.stop_err;
    new_entry.par_err = rx_char.par_err && (parity_on || bus_auto);
    new_entry.overrun = ovf_pend_q;
  end

  always_comb begin
    rx_high = 8'h00;
    rx_high[`RXH_COMPLETE] = count_q != 2'h0;
    if (count_q != 2'h0) begin
      rx_high[`RXH_OVERRUN] = head.overrun && !spi_master;
      rx_high[`RXH_STOP_ERR] = head.stop_err;
      rx_high[`RXH_PAR_ERR] = head.par_err && (parity_on || bus_auto);
      rx_high[`RXH_BIT8] = head.data[8];
    end
  end

  // Status byte; receive completion and empty flags are live levels
  always_comb begin
    status = 8'h00;
    status[`ST_RXC] = count_q != 2'h0;
    status[`ST_TXC] = txc_q;
    status[`ST_DRE] = dre_q;
    status[`ST_RXS] = rxs_q;
  end

  // Receive FIFO storage and pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (!rx_enable) begin
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      // slot after live entries; a same-cycle pop frees the head
      if (push) begin
        fifo_q[rd_ptr_q ^ count_q[0]] <= new_entry;
      end
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Pending overrun rides on the character now held in the shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_pend_q <= 1'b0;
    end else if (!rx_enable) begin
      ovf_pend_q <= 1'b0;
    end else if (count_q == 2'h2 && rx_shift_full && rx_start_det && !spi_master) begin
      ovf_pend_q <= 1'b1;
    end else if (push) begin
      ovf_pend_q <= 1'b0;
    end
  end

  // Full indication back to the shifter, registered for a clean output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q <= 1'b0;
    end else begin
      full_q <= rx_enable && ((count_q + {1'b0, push} - {1'b0, pop}) == 2'h2);
    end
  end

  // Transmit holding buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_low_q <= `RST_BYTE;
      tx_bit8_q <= 1'b0;
      dre_q <= 1'b1;
      tx_wait_high_q <= 1'b0;
    end else begin
      if (wr && idx == `IDX_TX_LOW && dre_q) begin
        tx_low_q <= pwdata[7:0];
        dre_q <= 1'b0;
        tx_wait_high_q <= low_first(size);
      end else if (load) begin
        dre_q <= 1'b1;
      end
      if (wr && idx == `IDX_TX_HIGH) begin
        tx_bit8_q <= pwdata[0];
        tx_wait_high_q <= 1'b0;
      end
    end
  end

  assign load = !dre_q && !tx_wait_high_q && rxtx_en_q[`EN_TX] && tx_shift_empty && !tx_load_q;

  // Load strobe and character to the shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_load_q <= 1'b0;
      tx_load_data_q <= 9'h000;
    end else begin
      tx_load_q <= load;
      if (load) begin
        tx_load_data_q <= mask_char({tx_bit8_q, tx_low_q}, size);
      end
    end
  end

  // Configuration registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= `RST_BYTE;
      rxtx_en_q <= `RST_BYTE;
      frame_q <= `RST_BYTE;
      baud_lo_q <= `RST_BYTE;
      baud_hi_q <= `RST_BYTE;
      dbg_q <= `RST_BYTE;
      evt_q <= `RST_BYTE;
      txpl_q <= `RST_BYTE;
      rxpl_q <= `RST_BYTE;
    end else if (wr) begin
      case (idx)
        `IDX_IRQ_EN: irq_en_q <= pwdata[7:0];
        `IDX_RXTX_EN: rxtx_en_q <= pwdata[7:0] & 8'hDF;
        `IDX_FRAME: frame_q <= pwdata[7:0];
        `IDX_BAUD_LO: baud_lo_q <= pwdata[7:0];
        `IDX_BAUD_HI: baud_hi_q <= pwdata[7:0];
        `IDX_DBG: dbg_q <= pwdata[7:0] & 8'h01;
        `IDX_EVT: evt_q <= pwdata[7:0] & 8'h01;
        `IDX_TXPL: txpl_q <= pwdata[7:0];
        `IDX_RXPL: rxpl_q <= pwdata[7:0] & 8'h7F;
        default: ;
      endcase
    end
  end

  // Sticky event flags; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc_q <= 1'b0;
      rxs_q <= 1'b0;
    end else begin
      if (tx_done && dre_q) begin
        txc_q <= 1'b1;
      end else if (wr && idx == `IDX_STATUS && pwdata[`ST_TXC]) begin
        txc_q <= 1'b0;
      end
      if (rx_start_det && rxtx_en_q[`EN_SFD]) begin
        rxs_q <= 1'b1;
      end else if (wr && idx == `IDX_STATUS && pwdata[`ST_RXS]) begin
        rxs_q <= 1'b0;
      end
    end
  end

  // Interrupt level from enabled status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status & irq_en_q & 8'hF0);
    end
  end

  // APB handshake: one wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      rd_had_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !addr_ok;
      // Remember whether the captured read saw a character
      rd_had_q <= count_q != 2'h0;
      prdata_q <= 32'h0000_0000;
      if (psel && penable && !pready_q && !pwrite && addr_ok) begin
        case (idx)
          `IDX_RX_LOW: prdata_q[7:0] <= (count_q != 2'h0) ? head.data[7:0] : 8'h00;
          `IDX_RX_HIGH: prdata_q[7:0] <= rx_high;
          `IDX_TX_LOW: prdata_q[7:0] <= tx_low_q;
          `IDX_STATUS: prdata_q[7:0] <= status;
          `IDX_IRQ_EN: prdata_q[7:0] <= irq_en_q;
          `IDX_RXTX_EN: prdata_q[7:0] <= rxtx_en_q;
          `IDX_FRAME: prdata_q[7:0] <= frame_q;
          `IDX_BAUD_LO: prdata_q[7:0] <= baud_lo_q;
          `IDX_BAUD_HI: prdata_q[7:0] <= baud_hi_q;
          `IDX_DBG: prdata_q[7:0] <= dbg_q;
          `IDX_EVT: prdata_q[7:0] <= evt_q;
          `IDX_TXPL: prdata_q[7:0] <= txpl_q;
          `IDX_RXPL: prdata_q[7:0] <= rxpl_q;
          default: prdata_q[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rx_fifo_full = full_q;
  assign tx_load = tx_load_q;
  assign tx_load_data = tx_load_data_q;
  assign irq = irq_q;
  // Settings are register bits, no logic between
  assign line_cfg.rx_en = rxtx_en_q[`EN_RX];
  assign line_cfg.tx_en = rxtx_en_q[`EN_TX];
  assign line_cfg.char_size = frame_q[`FR_SIZE_HI:`FR_SIZE_LO];
  assign line_cfg.rx_mode = rxtx_en_q[`EN_RXMODE_HI:`EN_RXMODE_LO];
  assign line_cfg.cmode = frame_q[`FR_CMODE_HI:`FR_CMODE_LO];
  assign line_cfg.pmode = frame_q[`FR_PMODE_HI:`FR_PMODE_LO];
  assign line_cfg.baud = {baud_hi_q, baud_lo_q};

endmodule
`default_nettype wire

// ### usart_buf_sva.sv
// Port checker for the data buffer block
`timescale 1ns/1ps
`default_nettype none
`include "usart_buf_defines.svh"
module usart_buf_sva
  import usart_buf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Shift logic
  input wire logic rx_push,
  input wire logic rx_fifo_full,
  input wire logic tx_shift_empty,
  input wire logic tx_load,
  input wire logic [8:0] tx_load_data,
  input wire line_cfg_t line_cfg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Answer cycle of a receive high byte read
  logic rd_high;
  assign rd_high = pready && !pwrite && paddr[5:2] == `IDX_RX_HIGH;
  ack_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  ack_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  bad_addr_a: assert property (pready && paddr[5:2] == 4'hF |-> pslverr)
    else $error("unmapped index not refused");
  load_cause_a: assert property (tx_load |-> $past(tx_shift_empty) && $past(line_cfg.tx_en))
    else $error("load without empty shifter");
  load_pulse_a: assert property (tx_load |=> !tx_load)
    else $error("load pulse too long");
  short_mask_a: assert property (tx_load && line_cfg.char_size == `SIZE_5 |-> tx_load_data[8:5] == 4'h0)
    else $error("upper bits sent in short size");
  ninth_gate_a: assert property (tx_load && line_cfg.char_size < 3'h6 |-> !tx_load_data[8])
    else $error("ninth bit sent in short size");
  full_cause_a: assert property ($rose(rx_fifo_full) |-> $past(rx_push))
    else $error("fifo full without push");
  flush_a: assert property (!line_cfg.rx_en [*3] |-> !rx_fifo_full)
    else $error("fifo kept with receiver off");
  empty_flags_a: assert property (rd_high && !prdata[7] |-> prdata[6:0] == 7'h00)
    else $error("flags shown with empty fifo");
  par_off_a: assert property (rd_high && line_cfg.pmode == `PMODE_OFF
    && line_cfg.rx_mode != `RXMODE_BUS_AUTO |-> !prdata[1])
    else $error("parity flag with parity off");
endmodule
bind usart_data_buffer_regs usart_buf_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_push(rx_push), .rx_fifo_full(rx_fifo_full),
  .tx_shift_empty(tx_shift_empty), .tx_load(tx_load), .tx_load_data(tx_load_data),
  .line_cfg(line_cfg));
`default_nettype wire

// ### line_model.sv
// Behavioural model of the receive and transmit shift logic
`timescale 1ns/1ps
`default_nettype none
module line_model
  import usart_buf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Receive side
  output logic rx_push,
  output rx_char_t rx_char,
  output logic rx_shift_full,
  output logic rx_start_det,
  // Transmit side
  input wire logic tx_load,
  input wire logic [8:0] tx_load_data,
  output logic tx_shift_empty,
  output logic tx_done
);
  int busy = 30;
  int cnt;
  int n_load;
  logic [8:0] last_tx;
  // Idle receive side at time zero
  initial begin
    rx_push = 1'b0;
    rx_char = '0;
    rx_shift_full = 1'b0;
    rx_start_det = 1'b0;
  end
  // One character; stale data is inverted so it never looks valid
  task automatic send(input logic [8:0] d, input logic se, input logic pe, input logic rs);
    @(posedge pclk);
    rx_push <= 1'b1;
    rx_char <= '{d, se, pe, rs};
    rx_shift_full <= 1'b0;
    @(posedge pclk);
    rx_push <= 1'b0;
    rx_char <= ~rx_char;
  endtask
  // Shifter stuck with a character while a new start bit arrives
  task automatic ovr();
    @(posedge pclk);
    rx_shift_full <= 1'b1;
    rx_start_det <= 1'b1;
    @(posedge pclk);
    rx_start_det <= 1'b0;
  endtask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_empty <= 1'b1;
      tx_done <= 1'b0;
      cnt <= 0;
      n_load <= 0;
      last_tx <= '0;
    end else begin
      tx_done <= cnt == 1;
      if (tx_load) begin
        tx_shift_empty <= 1'b0;
        cnt <= busy;
        last_tx <= tx_load_data;
        n_load <= n_load + 1;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        tx_shift_empty <= cnt == 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### usart_data_buffer_regs_tb.sv
// Self-checking testbench for the data buffer block
`timescale 1ns/1ps
`default_nettype none
module usart_data_buffer_regs_tb;
  import usart_buf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic rx_push, rx_shift_full, rx_start_det, rx_fifo_full;
  logic tx_shift_empty, tx_done, tx_load;
  logic [5:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0] tx_load_data;
  logic [7:0] rd;
  logic er;
  rx_char_t rx_char;
  line_cfg_t line_cfg;
  int n_fail, total_checks;
  usart_data_buffer_regs i_usart_data_buffer_regs (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_push, .rx_char, .rx_shift_full,
    .rx_start_det, .rx_fifo_full, .tx_shift_empty, .tx_done, .tx_load, .tx_load_data,
    .line_cfg, .irq);
  line_model i_line_model (.pclk, .presetn, .rx_push, .rx_char, .rx_shift_full,
    .rx_start_det, .tx_load, .tx_load_data, .tx_shift_empty, .tx_done);
  // Free-running bus clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rdc(input logic [3:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk({1'b0, rd}, {1'b0, e});
  endtask
  // The interrupt output is registered
  task automatic irqc(input logic e);
    repeat (2) @(posedge pclk);
    chk({8'h00, irq}, {8'h00, e});
  endtask
  task automatic wload(input int n);
    repeat (300) if (i_line_model.n_load < n) @(posedge pclk);
  endtask
  task automatic t_reset();
    rdc(4'h0, 8'h00);
    rdc(4'h1, 8'h00);
    rdc(4'h2, 8'h00);
    rdc(4'h4, 8'h20);
  endtask
  task automatic t_rx();
    wr(4'h7, 8'h03);
    wr(4'h6, 8'h80);
    i_line_model.send(9'h0A5, 1'b1, 1'b0, 1'b0);
    i_line_model.send(9'h05A, 1'b0, 1'b0, 1'b0);
    i_line_model.send(9'h0FF, 1'b0, 1'b0, 1'b0);
    i_line_model.ovr();
    rdc(4'h1, 8'h84);
    rdc(4'h0, 8'hA5);
    i_line_model.send(9'h0C3, 1'b0, 1'b0, 1'b0);
    rdc(4'h1, 8'h80);
    rdc(4'h0, 8'h5A);
    rdc(4'h1, 8'hC0);
    rdc(4'h0, 8'hC3);
    rdc(4'h1, 8'h00);
    rdc(4'h0, 8'h00);
  endtask
  task automatic t_flush();
    i_line_model.send(9'h011, 1'b1, 1'b0, 1'b0);
    rdc(4'h4, 8'hA0);
    wr(4'h6, 8'h00);
    rdc(4'h1, 8'h00);
    wr(4'h6, 8'h80);
    rdc(4'h4, 8'h20);
  endtask
  // A character lands in the very cycle the head is popped, then no overrun in SPI master
  task automatic t_pushpop();
    i_line_model.send(9'h061, 1'b0, 1'b0, 1'b0);
    i_line_model.send(9'h062, 1'b0, 1'b0, 1'b0);
    rdc(4'h1, 8'h80);
    chk({8'h00, rx_fifo_full}, 9'h001);
    fork
      rdc(4'h0, 8'h61);
      begin
        repeat (2) @(posedge pclk);
        i_line_model.send(9'h063, 1'b0, 1'b0, 1'b0);
      end
    join
    rdc(4'h0, 8'h62);
    rdc(4'h0, 8'h63);
    rdc(4'h1, 8'h00);
    wr(4'h7, 8'hC3);
    i_line_model.send(9'h071, 1'b0, 1'b0, 1'b0);
    i_line_model.send(9'h072, 1'b0, 1'b0, 1'b0);
    i_line_model.ovr();
    rdc(4'h0, 8'h71);
    i_line_model.send(9'h073, 1'b0, 1'b0, 1'b0);
    rdc(4'h0, 8'h72);
    rdc(4'h1, 8'h80);
    rdc(4'h0, 8'h73);
    wr(4'h7, 8'h03);
  endtask
  // Parity on, parity off, then bus auto-baud identifier and response
  task automatic t_par();
    logic [7:0] fr[4] = '{8'h23, 8'h03, 8'h03, 8'h03};
    logic [7:0] ct[4] = '{8'h80, 8'h80, 8'h86, 8'h86};
    logic [7:0] ex[4] = '{8'h82, 8'h80, 8'h82, 8'h81};
    for (int k = 0; k < 4; k++) begin
      wr(4'h7, fr[k]);
      wr(4'h6, ct[k]);
      i_line_model.send({k == 2, 8'h3C}, 1'b0, k != 3, k == 3);
      rdc(4'h1, ex[k]);
      rdc(4'h0, 8'h3C);
    end
  endtask
  task automatic t_short();
    wr(4'h6, 8'h80);
    wr(4'h7, 8'h00);
    i_line_model.send(9'h1FF, 1'b0, 1'b0, 1'b0);
    rdc(4'h1, 8'h80);
    rdc(4'h0, 8'h1F);
    wr(4'h7, 8'h06);
    i_line_model.send(9'h1C3, 1'b0, 1'b0, 1'b0);
    rdc(4'h0, 8'hC3);
    rdc(4'h1, 8'h81);
    rdc(4'h1, 8'h00);
  endtask
  // Slow shifter keeps the buffer full while more writes arrive
  task automatic t_tx();
    wr(4'h6, 8'hC0);
    wr(4'h7, 8'h07);
    wr(4'h3, 8'h01);
    wr(4'h2, 8'h3C);
    wload(1);
    chk(i_line_model.last_tx, 9'h13C);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h11);
    rdc(4'h4, 8'h00);
    wr(4'h2, 8'h22);
    repeat (80) @(posedge pclk);
    chk(9'(i_line_model.n_load), 9'h002);
    chk(i_line_model.last_tx, 9'h011);
    rdc(4'h4, 8'h60);
    wr(4'h7, 8'h06);
    wr(4'h2, 8'h55);
    rdc(4'h4, 8'h40);
    wr(4'h3, 8'h01);
    wload(3);
    chk(i_line_model.last_tx, 9'h155);
    wr(4'h7, 8'h00);
    wr(4'h2, 8'hFF);
    wload(4);
    chk(i_line_model.last_tx, 9'h01F);
    repeat (40) @(posedge pclk);
  endtask
  task automatic t_irq();
    wr(4'h5, 8'h40);
    irqc(1'b1);
    wr(4'h4, 8'h40);
    irqc(1'b0);
    wr(4'h5, 8'h80);
    i_line_model.send(9'h012, 1'b0, 1'b0, 1'b0);
    irqc(1'b1);
    wr(4'h5, 8'h00);
    irqc(1'b0);
    wr(4'h5, 8'h80);
    irqc(1'b1);
    rdc(4'h1, 8'h80);
    rdc(4'h0, 8'h12);
    irqc(1'b0);
    wr(4'h6, 8'h90);
    i_line_model.ovr();
    rdc(4'h4, 8'h30);
    wr(4'h4, 8'h10);
    rdc(4'h4, 8'h20);
  endtask
  // Plain settings registers: read-back masks and the settings bus
  task automatic t_cfg();
    wr(4'h8, 8'h34);
    wr(4'h9, 8'h12);
    @(posedge pclk);
    chk({1'b0, line_cfg.baud[7:0]}, 9'h034);
    chk({1'b0, line_cfg.baud[15:8]}, 9'h012);
    rdc(4'h9, 8'h12);
    wr(4'hB, 8'hFF);
    rdc(4'hB, 8'h01);
    wr(4'hE, 8'hFF);
    rdc(4'hE, 8'h7F);
    wr(4'h6, 8'hE0);
    rdc(4'h6, 8'hC0);
  endtask
  task automatic t_bus();
    apb(1'b0, 4'hF, 8'h00);
    chk({8'h00, er}, 9'h001);
    rdc(4'hA, 8'h00);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 6'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rx();
    t_flush();
    t_pushpop();
    t_par();
    t_short();
    t_tx();
    t_irq();
    t_cfg();
    t_bus();
    give_verdict();
  end
  // Watchdog well beyond the expected run
  initial begin
    #800000;
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
